// [design/sncp_pkg.sv]
// Constants and types shared by the serial NOR command port.
// Assumes one system clock that oversamples the serial pins of the host.
package sncp_pkg;

  // Instruction codes.
  localparam logic [7:0] OP_RD_STATUS        = 8'h05;
  localparam logic [7:0] OP_WR_ENABLE        = 8'h06;
  localparam logic [7:0] OP_WR_STATUS        = 8'h01;
  localparam logic [7:0] OP_PAGE_WRITE       = 8'h02;
  localparam logic [7:0] OP_FOUR_KIB_WIPE    = 8'h20;
  localparam logic [7:0] OP_HALF_WIPE        = 8'h52;
  localparam logic [7:0] OP_LARGE_BLOCK_WIPE = 8'hd8;
  localparam logic [7:0] OP_CHIP_WIPE_A      = 8'hc7;
  localparam logic [7:0] OP_CHIP_WIPE_B      = 8'h60;
  localparam logic [7:0] OP_READ             = 8'h03;
  localparam logic [7:0] OP_FAST_READ        = 8'h0b;
  localparam logic [7:0] OP_DUAL_READ        = 8'h3b;
  localparam logic [7:0] OP_DEEP_SLEEP       = 8'hb9;
  localparam logic [7:0] OP_WAKE_ID          = 8'hab;
  localparam logic [7:0] OP_MFR_DEV_ID       = 8'h90;
  localparam logic [7:0] OP_STD_ID_QUERY     = 8'h9f;
  localparam logic [7:0] OP_UNIQUE_ID        = 8'h4b;

  // Phase lengths in serial clock rising edges.
  localparam logic [5:0] CMD_BITS        = 6'h08;
  localparam logic [5:0] ADDR_BITS       = 6'h18;
  localparam logic [5:0] FAST_DUMMY_BITS = 6'h08;
  localparam logic [5:0] WAKE_DUMMY_BITS = 6'h18;
  localparam logic [5:0] UID_DUMMY_BITS  = 6'h20;

  // Status byte layout.
  localparam int SR_BUSY_BIT = 0;
  localparam int SR_PERMIT_BIT = 1;
  localparam int SR_BP_LSB   = 2;
  localparam int SR_LOCK_BIT = 7;

  // Embedded operation codes passed to the array engine.
  localparam logic [2:0] EOP_PAGE_BYTE = 3'h0;
  localparam logic [2:0] EOP_PAGE_END  = 3'h1;
  localparam logic [2:0] EOP_SECTOR    = 3'h2;
  localparam logic [2:0] EOP_HALF      = 3'h3;
  localparam logic [2:0] EOP_BLOCK     = 3'h4;
  localparam logic [2:0] EOP_CHIP      = 3'h5;
  localparam logic [2:0] EOP_STATUS    = 3'h6;

  typedef enum logic [2:0] {
    PH_IDLE, PH_CMD, PH_ADDR, PH_DUMMY, PH_DIN, PH_DOUT, PH_DONE, PH_IGN
  } sncp_phase_t;

  typedef struct packed {
    logic [2:0]  op;
    logic [23:0] addr;
    logic [7:0]  data;
  } sncp_cmd_t;

  typedef struct packed {
    logic        sck_q, cs_q, armed;
    sncp_phase_t ph;
    logic [5:0]  cnt, len;
    logic [7:0]  op;
    logic [23:0] addr;
    logic [7:0]  rx, tx;
    logic [2:0]  obit;
    logic [4:0]  bidx;
    logic        go, dual, d0, d1, oe0_n, oe1_n;
    logic        permit, busy, lock, sleep;
    logic [2:0]  bp;
    sncp_cmd_t   head, tail;
    logic        hv, tv, ovr;
  } sncp_state_t;

  localparam sncp_state_t SNCP_STATE_RST =
    '{ph: PH_IDLE, oe0_n: 1'b1, oe1_n: 1'b1, default: '0};

endpackage

// [design/sncp_top.sv]
// Command port of a small serial NOR flash, slave side of an SPI link.
// Serial pins are synchronous to sys_clk; the SPI clock must run at most sys_clk/8.
//
// Behaviour
// - Sample instruction, address and program data on each serial clock rising edge.
// - Change outgoing serial bits only on serial clock falling edges.
// - In dual reads line 0 takes input on rises and drives data on falls.
// - Chip select high floats both data lines and blocks instruction traffic.
// - Ignore everything after reset until chip select has been seen falling.
// - Write-protect pin with lock bit blocks status writes; nonzero protect bits block chip erase only.
// - Code 05h shifts the status byte out.
// - Code 06h sets the write permit latch.
// - Code 01h loads lock and protect bits from the host byte.
// - Code 02h programs up to 256 bytes, wrapping within one page.
// - Code 20h erases the addressed 4 KiB sector.
// - Code D8h erases a 64 KiB block, 52h a 32 KiB half block.
// - Codes C7h and 60h both erase the whole array.
// - Code 03h reads array bytes with auto-incrementing address.
// - Code 0Bh is a fast read on the single output line.
// - Code 3Bh returns two bits per clock on both data lines.
// - Code B9h enters deep sleep.
// - Code ABh leaves deep sleep and returns the device identifier byte.
// - Code 90h returns manufacturer and device identifiers.
// - Code 9Fh returns the standard identification sequence.
// - Code 4Bh returns a 128-bit unique identifier.
// - Clock modes 0 and 3 behave alike: sample on rises, drive on falls.
// - While busy, report busy and ignore all instructions but status read.
// - Write permit set only by 06h, cleared when an embedded operation completes.
`timescale 1ns/1ps
module sncp_top
  import sncp_pkg::*;
#(
  parameter logic [7:0]   MFR_ID    = 8'h5a,                // Arbitrary value.
  parameter logic [7:0]   DEV_ID    = 8'h11,                // Arbitrary value.
  parameter logic [23:0]  STD_ID    = 24'h5a4012,           // Arbitrary value.
  parameter logic [127:0] UNIQUE_ID = 128'h0123456789abcdef_fedcba9876543210 // Arbitrary.
) (
  // System
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Serial pins
  input  wire logic        spi_clk,
  input  wire logic        spi_cs_n,
  input  wire logic        data_line0,
  output logic             data_line0_drv,
  output logic             data_line0_oe_n,
  output logic             data_line1_drv,
  output logic             data_line1_oe_n,
  input  wire logic        write_protect_n,
  // Array read side
  output logic [23:0]      arr_rd_addr,
  input  wire logic [7:0]  arr_rd_data,
  // Embedded operation queue
  output sncp_cmd_t        cmd,
  output logic             cmd_valid,
  input  wire logic        cmd_ready,
  input  wire logic        op_done,
  // Status
  output logic             busy,
  output logic             write_permit_latch,
  output logic             status_lock,
  output logic [2:0]       protect_range,
  output logic             deep_sleep,
  output logic             cmd_overrun
);

  sncp_state_t st_r;
  sncp_state_t st_nxt;
  logic        rise;
  logic        fall;
  logic        cs_fall;
  logic        cs_rise;
  logic        pop;
  logic        room;
  logic [7:0]  opc;

  // Both clock modes reduce to the same edge pair, so idle level is irrelevant.
  assign rise    = spi_clk & ~st_r.sck_q;
  assign fall    = ~spi_clk & st_r.sck_q;
  assign cs_fall = ~spi_cs_n & st_r.cs_q;
  assign cs_rise = spi_cs_n & ~st_r.cs_q;
  assign opc     = {st_r.op[6:0], data_line0};
  assign pop     = st_r.hv & cmd_ready;
  assign room    = ~st_r.tv | pop;

  always_comb begin
    logic [7:0] cur;
    logic [7:0] stat;
    logic       push;
    sncp_cmd_t  pcmd;
    cur    = 8'h00;
    stat   = 8'h00;
    push   = 1'b0;
    pcmd   = '0;
    st_nxt = st_r;
    st_nxt.sck_q = spi_clk;
    st_nxt.cs_q  = spi_cs_n;
    stat[SR_BUSY_BIT]       = st_r.busy;
    stat[SR_PERMIT_BIT]     = st_r.permit;
    stat[SR_BP_LSB +: 3]    = st_r.bp;
    stat[SR_LOCK_BIT]       = st_r.lock;
    if (pop) begin
      st_nxt.head = st_r.tail;
      st_nxt.hv   = st_r.tv;
      st_nxt.tv   = 1'b0;
    end
    if (op_done) begin
      st_nxt.busy = 1'b0;
      st_nxt.permit = 1'b0;
    end
    if (spi_cs_n) begin
      st_nxt.oe0_n = 1'b1;
      st_nxt.oe1_n = 1'b1;
    end
    if (cs_fall) begin
      st_nxt.armed = 1'b1;
      st_nxt.ph    = PH_CMD;
      st_nxt.cnt   = '0;
      st_nxt.go    = 1'b0;
      st_nxt.obit  = '0;
      st_nxt.bidx  = '0;
      st_nxt.dual  = 1'b0;
    end else if (cs_rise) begin
      // A partial instruction never sets go, so it leaves no trace here.
      st_nxt.ph = PH_IDLE;
      if (st_r.go) begin
        pcmd.addr = st_r.addr;
        pcmd.data = st_r.rx;
        unique case (st_r.op)
          OP_WR_STATUS: begin
            pcmd.op = EOP_STATUS;
            if (!(st_r.lock && !write_protect_n) && room) begin
              st_nxt.lock = st_r.rx[SR_LOCK_BIT];
              st_nxt.bp   = st_r.rx[SR_BP_LSB +: 3];
              push        = 1'b1;
            end
          end
          OP_PAGE_WRITE: begin
            pcmd.op = EOP_PAGE_END;
            push    = room;
          end
          OP_FOUR_KIB_WIPE: begin
            pcmd.op = EOP_SECTOR;
            push    = room;
          end
          OP_HALF_WIPE: begin
            pcmd.op = EOP_HALF;
            push    = room;
          end
          OP_LARGE_BLOCK_WIPE: begin
            pcmd.op = EOP_BLOCK;
            push    = room;
          end
          OP_CHIP_WIPE_A, OP_CHIP_WIPE_B: begin
            pcmd.op = EOP_CHIP;
            push    = room && (st_r.bp == 3'h0);
          end
          OP_DEEP_SLEEP: st_nxt.sleep = 1'b1;
          default: ;
        endcase
        // Busy set after the op_done clear above, so a new start wins.
        if (push) begin
          st_nxt.busy = 1'b1;
        end
        if (!room && st_r.op != OP_DEEP_SLEEP) begin
          st_nxt.ovr = 1'b1;
        end
      end
    end else if (!spi_cs_n && st_r.armed && rise) begin
      st_nxt.cnt = st_r.cnt + 6'h01;
      unique case (st_r.ph)
        PH_CMD: begin
          st_nxt.op = opc;
          if (st_r.cnt == CMD_BITS - 6'h01) begin
            st_nxt.cnt = '0;
            st_nxt.ph  = PH_IGN;
            if (!(st_r.busy && opc != OP_RD_STATUS) &&
                !(st_r.sleep && opc != OP_WAKE_ID)) begin
              unique case (opc)
                OP_RD_STATUS, OP_STD_ID_QUERY: st_nxt.ph = PH_DOUT;
                OP_WR_ENABLE: begin
                  st_nxt.permit = 1'b1;
                  st_nxt.ph  = PH_DONE;
                end
                OP_WR_STATUS: if (st_r.permit) st_nxt.ph = PH_DIN;
                OP_PAGE_WRITE, OP_FOUR_KIB_WIPE, OP_HALF_WIPE, OP_LARGE_BLOCK_WIPE: begin
                  if (st_r.permit) st_nxt.ph = PH_ADDR;
                end
                OP_CHIP_WIPE_A, OP_CHIP_WIPE_B: begin
                  if (st_r.permit) begin
                    st_nxt.ph = PH_DONE;
                    st_nxt.go = 1'b1;
                  end
                end
                OP_READ, OP_FAST_READ, OP_MFR_DEV_ID: st_nxt.ph = PH_ADDR;
                OP_DUAL_READ: begin
                  st_nxt.ph   = PH_ADDR;
                  st_nxt.dual = 1'b1;
                end
                OP_DEEP_SLEEP: begin
                  st_nxt.ph = PH_DONE;
                  st_nxt.go = 1'b1;
                end
                OP_WAKE_ID: begin
                  st_nxt.sleep = 1'b0;
                  st_nxt.ph    = PH_DUMMY;
                  st_nxt.len   = WAKE_DUMMY_BITS;
                end
                OP_UNIQUE_ID: begin
                  st_nxt.ph  = PH_DUMMY;
                  st_nxt.len = UID_DUMMY_BITS;
                end
                default: ;
              endcase
            end
          end
        end
        PH_ADDR: begin
          st_nxt.addr = {st_r.addr[22:0], data_line0};
          if (st_r.cnt == ADDR_BITS - 6'h01) begin
            st_nxt.cnt = '0;
            unique case (st_r.op)
              OP_PAGE_WRITE: begin
                st_nxt.ph = PH_DIN;
                st_nxt.go = 1'b1;
              end
              OP_READ, OP_MFR_DEV_ID: st_nxt.ph = PH_DOUT;
              OP_FAST_READ, OP_DUAL_READ: begin
                st_nxt.ph  = PH_DUMMY;
                st_nxt.len = FAST_DUMMY_BITS;
              end
              default: begin
                st_nxt.ph = PH_DONE;
                st_nxt.go = 1'b1;
              end
            endcase
          end
        end
        PH_DUMMY: begin
          if (st_r.cnt == st_r.len - 6'h01) begin
            st_nxt.ph  = PH_DOUT;
            st_nxt.cnt = '0;
          end
        end
        PH_DIN: begin
          st_nxt.rx = {st_r.rx[6:0], data_line0};
          if (st_r.cnt[2:0] == 3'h7) begin
            if (st_r.op == OP_PAGE_WRITE) begin
              pcmd.op   = EOP_PAGE_BYTE;
              pcmd.addr = st_r.addr;
              pcmd.data = {st_r.rx[6:0], data_line0};
              push      = room;
              if (!room) begin
                st_nxt.ovr = 1'b1;
              end
              // Only the low byte advances, so a long burst wraps in the page.
              st_nxt.addr[7:0] = st_r.addr[7:0] + 8'h01;
            end else begin
              st_nxt.go = 1'b1;
              st_nxt.ph = PH_DONE;
            end
          end
        end
        PH_IDLE, PH_DOUT, PH_DONE, PH_IGN: ;
      endcase
    end
    if (!spi_cs_n && fall && st_r.ph == PH_DOUT) begin
      if (st_r.obit == 3'h0) begin
        unique case (st_r.op)
          OP_RD_STATUS: cur = stat;
          OP_STD_ID_QUERY: begin
            cur = (st_r.bidx == 5'h00) ? STD_ID[23:16] :
                  (st_r.bidx == 5'h01) ? STD_ID[15:8] : STD_ID[7:0];
          end
          OP_WAKE_ID:    cur = DEV_ID;
          OP_MFR_DEV_ID: cur = (st_r.bidx[0] ^ st_r.addr[0]) ? DEV_ID : MFR_ID;
          OP_UNIQUE_ID:  cur = UNIQUE_ID[{~st_r.bidx[3:0], 3'h0} +: 8];
          default:       cur = arr_rd_data;
        endcase
        st_nxt.bidx = st_r.bidx + 5'h01;
        if (st_r.op == OP_READ || st_r.op == OP_FAST_READ || st_r.op == OP_DUAL_READ) begin
          st_nxt.addr = st_r.addr + 24'h000001;
        end
      end else begin
        cur = st_r.tx;
      end
      st_nxt.d1    = cur[7];
      st_nxt.d0    = cur[6];
      st_nxt.tx    = st_r.dual ? (cur << 2) : (cur << 1);
      st_nxt.obit  = st_r.obit + (st_r.dual ? 3'h2 : 3'h1);
      st_nxt.oe1_n = 1'b0;
      st_nxt.oe0_n = ~st_r.dual;
    end
    if (push) begin
      if (!st_nxt.hv) begin
        st_nxt.head = pcmd;
        st_nxt.hv   = 1'b1;
      end else begin
        st_nxt.tail = pcmd;
        st_nxt.tv   = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r <= SNCP_STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign data_line0_drv     = st_r.d0;
  assign data_line0_oe_n    = st_r.oe0_n;
  assign data_line1_drv     = st_r.d1;
  assign data_line1_oe_n    = st_r.oe1_n;
  assign arr_rd_addr        = st_r.addr;
  assign cmd                = st_r.head;
  assign cmd_valid          = st_r.hv;
  assign busy               = st_r.busy;
  assign write_permit_latch = st_r.permit;
  assign status_lock        = st_r.lock;
  assign protect_range      = st_r.bp;
  assign deep_sleep         = st_r.sleep;
  assign cmd_overrun        = st_r.ovr;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_cmd_done;
    !spi_cs_n && st_r.armed && rise && st_r.ph == PH_CMD && st_r.cnt == 6'h07;
  endsequence
  sequence s_locked_wr;
    cs_rise && st_r.go && st_r.op == OP_WR_STATUS && st_r.lock && !write_protect_n;
  endsequence
  sequence s_chip_commit;
    cs_rise && st_r.go && (st_r.op == OP_CHIP_WIPE_A || st_r.op == OP_CHIP_WIPE_B) &&
      st_r.bp == 3'h0 && room;
  endsequence

  a_sample_rise:
    assert property (!rise |=> $stable(st_r.rx) && $stable(st_r.op))
    else $error("Input shifted without a rising serial clock edge.");
  a_drive_falling:
    assert property (!fall |=> $stable(data_line1_drv) && $stable(data_line0_drv))
    else $error("Output bit changed without a falling serial clock edge.");
  a_dual_drive:
    assert property (st_r.dual && !data_line1_oe_n |-> !data_line0_oe_n)
    else $error("Dual read does not drive data line 0.");
  a_float_deselect:
    assert property (spi_cs_n |=> data_line0_oe_n && data_line1_oe_n)
    else $error("Data line driven while deselected.");
  a_arm_first:
    assert property (!st_r.armed |-> st_r.ph == PH_IDLE && !st_r.permit)
    else $error("Activity before the first chip select fall.");
  a_status_lock:
    assert property (s_locked_wr |=> $stable(st_r.bp) && st_r.lock && !$rose(st_r.busy))
    else $error("Locked status register was written.");
  a_permit_set:
    assert property (s_cmd_done ##0 (opc == OP_WR_ENABLE && !st_r.busy && !st_r.sleep)
                     |=> write_permit_latch)
    else $error("Write enable did not set the latch.");
  a_busy_ignore:
    assert property (s_cmd_done ##0 (st_r.busy && opc != OP_RD_STATUS) |=> st_r.ph == PH_IGN)
    else $error("Instruction accepted while busy.");
  a_done_clears:
    assert property (op_done && !(cs_rise && st_r.go) &&
                     !(rise && st_r.ph == PH_CMD && st_r.cnt == 6'h07 &&
                       opc == OP_WR_ENABLE)
                     |=> !busy && !write_permit_latch)
    else $error("Completion did not clear busy and write permit.");
  a_abandon_cmd:
    assert property (cs_rise && st_r.ph == PH_CMD |=> st_r.ph == PH_IDLE && !$rose(st_r.busy))
    else $error("Partial instruction was not abandoned.");
  a_chip_wipe:
    assert property (s_chip_commit |=> st_r.busy && st_r.hv)
    else $error("Chip erase not queued.");
  a_dual_pace:
    assert property (fall && !spi_cs_n && st_r.ph == PH_DOUT && st_r.dual
                     |=> st_r.obit == 3'($past(st_r.obit) + 3'h2))
    else $error("Dual read not two bits per clock.");

endmodule  // sncp_top

// [verif/sncp_host_model.sv]
// Behavioural SPI host that drives the serial pins of the command port.
// Assumes the bench resolves both data lines and calls these tasks one after another.
`timescale 1ns/1ps
module sncp_host_model (
  // Clock
  input  wire logic sys_clk,
  // Serial pins
  output logic      spi_clk,
  output logic      spi_cs_n,
  output logic      host_dout,
  input  wire logic line0,
  input  wire logic line1
);
  logic mode3;

  initial begin
    mode3     = 1'b0;
    spi_clk   = 1'b0;
    // Low from power-up on purpose, so the bench can show that a frame without a fall is ignored.
    spi_cs_n  = 1'b0;
    host_dout = 1'b0;
  end

  task automatic pause(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Half periods of four system cycles keep the link at the fastest legal ratio.
  task automatic start();
    spi_clk = mode3;
    pause(4);
    spi_cs_n = 1'b0;
    pause(4);
  endtask

  // Sends n bits of b and gathers the lines on each rise, two bits a clock when dual.
  task automatic shift(input logic [7:0] b, input int n, input bit dual, output logic [7:0] r);
    r = 8'h00;
    for (int i = 0; i < n; i++) begin
      spi_clk   = 1'b0;
      host_dout = b[7-i];
      pause(4);
      spi_clk = 1'b1;
      r = dual ? {r[5:0], line1, line0} : {r[6:0], line1};
      pause(4);
    end
  endtask

  task automatic stop();
    if (!mode3) spi_clk = 1'b0;
    pause(4);
    spi_cs_n = 1'b1;
    // The line toggles between frames so that no stale bit can pass for a good one.
    host_dout = ~host_dout;
    pause(10);
  endtask
endmodule // sncp_host_model

// [verif/serial_nor_command_port_tb_top.sv]
// Self-checking bench for the serial NOR command port.
// Assumes the host model on the serial pins and a combinational array image on the read side.
`timescale 1ns/1ps
module serial_nor_command_port_tb_top;
  import sncp_pkg::*;
  localparam logic [7:0]   T_MFR = 8'hc3;          // Arbitrary value.
  localparam logic [7:0]   T_DEV = 8'h2e;          // Arbitrary value.
  localparam logic [23:0]  T_STD = 24'hc3402e;     // Arbitrary value.
  localparam logic [127:0] T_UID = 128'h9a3b_7c11_0d5e_42f6_8812_30ab_c4d9_e7f0; // Arbitrary.

  logic        sys_clk, sys_rst, spi_clk, spi_cs_n, host_dout, line0, line1;
  logic        d0_drv, d0_oe_n, d1_drv, d1_oe_n, write_protect_n;
  logic [23:0] arr_rd_addr;
  logic [7:0]  arr_rd_data;
  sncp_cmd_t   cmd;
  logic        cmd_valid, cmd_ready, op_done, busy, write_permit_latch, status_lock;
  logic [2:0]  protect_range;
  logic        deep_sleep, cmd_overrun, saw_dual;
  logic [31:0] rd;
  int          bad_count, total_checks, cycles;

  function automatic logic [7:0] mem(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction

  assign line0       = d0_oe_n ? host_dout : d0_drv;
  assign line1       = d1_oe_n ? 1'bz : d1_drv;
  assign arr_rd_data = mem(arr_rd_addr);

  sncp_top #(.MFR_ID(T_MFR), .DEV_ID(T_DEV), .STD_ID(T_STD), .UNIQUE_ID(T_UID)) uut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .data_line0(line0), .data_line0_drv(d0_drv), .data_line0_oe_n(d0_oe_n),
    .data_line1_drv(d1_drv), .data_line1_oe_n(d1_oe_n), .write_protect_n(write_protect_n),
    .arr_rd_addr(arr_rd_addr), .arr_rd_data(arr_rd_data), .cmd(cmd), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .op_done(op_done), .busy(busy),
    .write_permit_latch(write_permit_latch), .status_lock(status_lock),
    .protect_range(protect_range), .deep_sleep(deep_sleep), .cmd_overrun(cmd_overrun));

  sncp_host_model host (.sys_clk(sys_clk), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .host_dout(host_dout), .line0(line0), .line1(line1));

  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (!d0_oe_n) saw_dual <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      results();
    end
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One whole frame: opcode, nb bytes of a, then nr bytes read back.
  task automatic xact(input logic [7:0] op, input logic [63:0] a, input int nb, input int nr,
                      input bit dual);
    logic [7:0] r;
    host.start();
    host.shift(op, 8, 1'b0, r);
    for (int k = nb - 1; k >= 0; k--) host.shift(a[8*k +: 8], 8, 1'b0, r);
    rd = '0;
    for (int k = 0; k < nr; k++) begin
      host.shift(8'h00, dual ? 4 : 8, dual, r);
      rd = {rd[23:0], r};
    end
    host.stop();
  endtask

  task automatic wen();
    xact(OP_WR_ENABLE, 64'h0, 0, 0, 1'b0);
  endtask

  task automatic wait_valid();
    for (int i = 0; i < 40 && cmd_valid !== 1'b1; i++) @(negedge sys_clk);
  endtask

  // Pops the head; sel 1 compares the address, sel 2 the address and the data too.
  task automatic pop(input logic [2:0] op, input logic [31:0] ad, input int sel);
    wait_valid();
    check("cmd_valid", cmd_valid, 1'b1);
    check("cmd_op", cmd.op, op);
    if (sel == 1) check("cmd_addr", cmd.addr, ad[31:8]);
    if (sel == 2) check("cmd_addr_data", {cmd.addr, cmd.data}, ad);
    cmd_ready = 1'b1;
    @(negedge sys_clk);
    cmd_ready = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic finish_op();
    op_done = 1'b1;
    @(negedge sys_clk);
    op_done = 1'b0;
    @(negedge sys_clk);
    check("busy", busy, 1'b0);
    check("latch", write_permit_latch, 1'b0);
  endtask

  task automatic t_arm();
    logic [7:0] r;
    host.shift(OP_WR_ENABLE, 8, 1'b0, r);
    host.stop();
    check("latch_no_fall", write_permit_latch, 1'b0);
    host.start();
    host.shift(OP_WR_ENABLE, 4, 1'b0, r);
    host.stop();
    check("latch_partial", write_permit_latch, 1'b0);
    wen();
    check("latch_set", write_permit_latch, 1'b1);
    check("line1_float", d1_oe_n, 1'b1);
    $display("test arm done");
  endtask

  task automatic t_status();
    host.mode3 = 1'b1;
    xact(OP_RD_STATUS, 64'h0, 0, 1, 1'b0);
    check("status_mode3", rd[7:0], 8'h02);
    check("line1_released", d1_oe_n, 1'b1);
    host.mode3 = 1'b0;
    xact(OP_RD_STATUS, 64'h0, 0, 2, 1'b0);
    check("status_twice", rd[15:0], 16'h0202);
    $display("test status done");
  endtask

  task automatic t_erase();
    logic [7:0] ops [5] = '{OP_FOUR_KIB_WIPE, OP_HALF_WIPE, OP_LARGE_BLOCK_WIPE,
                            OP_CHIP_WIPE_A, OP_CHIP_WIPE_B};
    logic [2:0] eops [5] = '{EOP_SECTOR, EOP_HALF, EOP_BLOCK, EOP_CHIP, EOP_CHIP};
    for (int i = 0; i < 5; i++) begin
      wen();
      xact(ops[i], 64'h012345, i < 3 ? 3 : 0, 0, 1'b0);
      wait_valid();
      check("busy_set", busy, 1'b1);
      if (i == 0) begin
        xact(OP_RD_STATUS, 64'h0, 0, 1, 1'b0);
        check("status_busy", rd[7:0], 8'h03);
        xact(OP_READ, 64'h0, 3, 1, 1'b0);
        check("read_refused", rd[7:0], 8'hzz);
      end
      pop(eops[i], 32'h01234500, i < 3 ? 1 : 0);
      finish_op();
    end
    xact(OP_FOUR_KIB_WIPE, 64'h012345, 3, 0, 1'b0);
    check("no_latch", cmd_valid, 1'b0);
    $display("test erase done");
  endtask

  task automatic t_protect();
    wen();
    xact(OP_WR_STATUS, 64'h9c, 1, 0, 1'b0);
    wait_valid();
    check("status_byte", cmd.data, 8'h9c);
    pop(EOP_STATUS, 32'h0, 0);
    finish_op();
    check("lock_range", {status_lock, protect_range}, 4'hf);
    wen();
    xact(OP_CHIP_WIPE_A, 64'h0, 0, 0, 1'b0);
    check("chip_guarded", cmd_valid, 1'b0);
    write_protect_n = 1'b0;
    wen();
    xact(OP_WR_STATUS, 64'h00, 1, 0, 1'b0);
    check("status_guarded", cmd_valid, 1'b0);
    write_protect_n = 1'b1;
    wen();
    xact(OP_WR_STATUS, 64'h00, 1, 0, 1'b0);
    pop(EOP_STATUS, 32'h0, 0);
    finish_op();
    check("lock_clear", {status_lock, protect_range}, 4'h0);
    $display("test protect done");
  endtask

  task automatic t_reads();
    xact(OP_READ, 64'h0001fe, 3, 3, 1'b0);
    check("read", rd[23:0], {mem(24'h1fe), mem(24'h1ff), mem(24'h200)});
    xact(OP_FAST_READ, 64'h00abcd00, 4, 2, 1'b0);
    check("fast", rd[15:0], {mem(24'habcd), mem(24'habce)});
    saw_dual = 1'b0;
    xact(OP_DUAL_READ, 64'h00031000, 4, 2, 1'b1);
    check("dual", rd[15:0], {mem(24'h310), mem(24'h311)});
    check("line0_drove", saw_dual, 1'b1);
    $display("test reads done");
  endtask

  task automatic t_ids();
    xact(OP_STD_ID_QUERY, 64'h0, 0, 3, 1'b0);
    check("std_id", rd[23:0], T_STD);
    xact(OP_MFR_DEV_ID, 64'h0, 3, 2, 1'b0);
    check("mfr_dev", rd[15:0], {T_MFR, T_DEV});
    xact(OP_MFR_DEV_ID, 64'h1, 3, 2, 1'b0);
    check("dev_mfr", rd[15:0], {T_DEV, T_MFR});
    xact(OP_UNIQUE_ID, 64'h0, 4, 4, 1'b0);
    check("unique_id", rd, T_UID[127:96]);
    xact(OP_DEEP_SLEEP, 64'h0, 0, 0, 1'b0);
    check("asleep", deep_sleep, 1'b1);
    xact(OP_RD_STATUS, 64'h0, 0, 1, 1'b0);
    check("sleep_quiet", rd[7:0], 8'hzz);
    xact(OP_WAKE_ID, 64'h0, 3, 1, 1'b0);
    check("wake_id", {deep_sleep, rd[7:0]}, {1'b0, T_DEV});
    $display("test ids done");
  endtask

  // The consumer stalls, so two bytes fill the queue and the page end finds no room.
  task automatic t_page();
    wen();
    xact(OP_PAGE_WRITE, 64'h0001ffa53c, 5, 0, 1'b0);
    check("overrun", cmd_overrun, 1'b1);
    pop(EOP_PAGE_BYTE, 32'h0001ffa5, 2);
    pop(EOP_PAGE_BYTE, 32'h0001003c, 2);
    check("drained", cmd_valid, 1'b0);
    finish_op();
    $display("test page done");
  endtask

  task automatic results();
    $display("Checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    write_protect_n = 1'b1;
    cmd_ready = 1'b0;
    op_done = 1'b0;
    saw_dual = 1'b0;
    bad_count = 0;
    total_checks = 0;
    cycles = 0;
    repeat (12) @(negedge sys_clk);
    sys_rst = 1'b0;
    @(negedge sys_clk);
    t_arm();
    t_status();
    t_erase();
    t_protect();
    t_reads();
    t_ids();
    t_page();
    results();
  end
endmodule // serial_nor_command_port_tb_top
